// file: inc/mode_burst_pkg.sv
// Constants and types for the mode-register burst and DLL control block.
`default_nettype none
package mode_burst_pkg;
    localparam int unsigned ADDR_W          = 14;
    localparam int unsigned BEAT_W          = 3;
    localparam int unsigned BEATS_FULL      = 8;
    localparam int unsigned BEATS_CHOP      = 4;
    // First mode register fields.
    localparam int unsigned MRF_BL_LO       = 0;
    localparam int unsigned MRF_BL_HI       = 1;
    localparam int unsigned MRF_BT          = 3;
    localparam int unsigned MRF_DLL_RST     = 8;
    localparam int unsigned MRF_WR_LO       = 9;
    localparam int unsigned MRF_WR_HI       = 11;
    localparam int unsigned MRF_PPD         = 12;
    // Second mode register fields.
    localparam int unsigned MRS_DLL_DIS     = 0;
    localparam int unsigned MRS_DRV_A       = 1;
    localparam int unsigned MRS_RTT_A       = 2;
    localparam int unsigned MRS_DRV_B       = 5;
    localparam int unsigned MRS_RTT_B       = 6;
    localparam int unsigned MRS_WLVL        = 7;
    localparam int unsigned MRS_RTT_C       = 9;
    localparam int unsigned MRS_QOFF        = 12;
    // Third mode register write termination field.
    localparam int unsigned MRT_RTTWR_LO    = 9;
    localparam int unsigned MRT_RTTWR_HI    = 10;
    localparam int unsigned CHOP_ADDR_BIT   = 12;
    localparam int unsigned COL_HALF_BIT    = 2;
    // Burst length field encoding.
    localparam logic [1:0]  BL_FIXED8       = 2'h0;
    localparam logic [1:0]  BL_OTF         = 2'h1;
    localparam logic [1:0]  BL_FIXED4       = 2'h2;
    // Bank codes for mode register selection.
    localparam logic [2:0]  BANK_MR_FIRST   = 3'h0;
    localparam logic [2:0]  BANK_MR_SECOND  = 3'h1;
    localparam logic [2:0]  BANK_MR_THIRD   = 3'h2;
    // Fixed chop writes start internally this many clocks early.
    localparam logic [1:0]  CHOP_WR_PULL_IN = 2'h2;
    localparam logic [ADDR_W-1:0] MR_FIRST_RST  = 14'h0000;
    localparam logic [ADDR_W-1:0] MR_SECOND_RST = 14'h0000;
    localparam logic [ADDR_W-1:0] MR_THIRD_RST  = 14'h0000;
    localparam logic [BEAT_W-1:0] BEAT_LAST_CHOP = 3'h3;
    localparam logic [BEAT_W-1:0] BEAT_LAST_FULL = 3'h7;

    typedef enum logic [1:0] {
        BURST_IDLE,
        BURST_READ,
        BURST_WRITE
    } burst_state_t;
endpackage : mode_burst_pkg
`default_nettype wire

// file: src/beat_order.sv
// Combinational column order for one beat of a read or write burst.
`timescale 1ns/1ps
`default_nettype none
module beat_order
    import mode_burst_pkg::*;
(
    input  wire logic [BEAT_W-1:0] start_col,
    input  wire logic [BEAT_W-1:0] beat,
    input  wire logic              interleave,
    input  wire logic              is_write,
    input  wire logic              chop,
    output logic      [BEAT_W-1:0] col
);
    always_comb begin
        if (is_write) begin
            if (chop) begin
                col = {start_col[COL_HALF_BIT], beat[1:0]};
            end else begin
                col = beat;
            end
        end else if (interleave) begin
            col = start_col ^ beat;
        end else begin
            // Wrap within each group of four; the upper beat bit flips the group.
            col = {start_col[2] ^ beat[2], 2'(start_col[1:0] + beat[1:0])};
        end
    end
endmodule : beat_order
`default_nettype wire

// file: src/mode_burst_ctrl.sv
// Mode register capture, burst ordering and DLL/termination control.
// Functional notes
// - A3 picks sequential or interleaved order.
// - A0-A1 pick chop, eight-beat or on-the-fly.
// - On the fly, A12 chooses burst length.
// - Sequential reads wrap within groups of four.
// - Interleaved reads use start XOR beat.
// - Chopped reads tristate for the last four.
// - Writes ignore start bits except chop half.
// - Fixed chop writes start two clocks earlier.
// - DLL reset bit clears itself after action.
// - A9-A11 hold auto-precharge write recovery.
// - A12 chooses slow or fast power-down exit.
// - Write leveling limits allowed termination settings; A7 is not decoded here, so no setting is limited.
// - DLL off in self-refresh, on at exit.
// - A1 and A5 pick driver impedance.
// - Write termination applies without nominal termination.
// - Writes need the DLL only with write termination.
`timescale 1ns/1ps
`default_nettype none
module mode_burst_ctrl
    import mode_burst_pkg::*;
(
    input  wire logic              clk_sys,
    input  wire logic              reset,
    input  wire logic              mrs_cmd,
    input  wire logic              rd_cmd,
    input  wire logic              wr_cmd,
    input  wire logic [2:0]        bank,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic              self_refresh,
    input  wire logic              precharge_pd,
    output logic      [BEAT_W-1:0] beat_col,
    output logic                   beat_valid,
    output logic                   beat_is_write,
    output logic                   dq_drive_n,
    output logic                   burst_interleave,
    output logic                   dll_reset_pulse,
    output logic                   dll_running,
    output logic                   dll_bit,
    output logic      [2:0]        write_recovery,
    output logic                   slow_pd_exit,
    output logic      [1:0]        drive_strength,
    output logic      [2:0]        rtt_nom_sel,
    output logic      [1:0]        rtt_wr_sel,
    output logic                   rtt_wr_active,
    output logic                   wr_needs_dll,
    output logic      [1:0]        wr_pull_in
);
    ////////////////////////////////////////////////////////////////////////
    // Mode registers.
    logic [ADDR_W-1:0] mr_first_r,  mr_first_nxt;
    logic [ADDR_W-1:0] mr_second_r, mr_second_nxt;
    logic [ADDR_W-1:0] mr_third_r,  mr_third_nxt;
    logic              dll_rst_r,   dll_rst_nxt;

    always_comb begin
        mr_first_nxt  = mr_first_r;
        mr_second_nxt = mr_second_r;
        mr_third_nxt  = mr_third_r;
        dll_rst_nxt   = 1'b0;
        // The reset request is consumed one cycle after capture.
        mr_first_nxt[MRF_DLL_RST] = 1'b0;
        if (mrs_cmd) begin
            unique case (bank)
                BANK_MR_FIRST: begin
                    mr_first_nxt = addr;
                    dll_rst_nxt  = addr[MRF_DLL_RST];
                end
                BANK_MR_SECOND: mr_second_nxt = addr;
                BANK_MR_THIRD:  mr_third_nxt  = addr;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            mr_first_r  <= MR_FIRST_RST;
            mr_second_r <= MR_SECOND_RST;
            mr_third_r  <= MR_THIRD_RST;
            dll_rst_r   <= 1'b0;
        end else begin
            mr_first_r  <= mr_first_nxt;
            mr_second_r <= mr_second_nxt;
            mr_third_r  <= mr_third_nxt;
            dll_rst_r   <= dll_rst_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Burst sequencer.
    burst_state_t      state_r,  state_nxt;
    logic [BEAT_W-1:0] beat_r,   beat_nxt;
    logic [BEAT_W-1:0] start_r,  start_nxt;
    logic              chop_r,   chop_nxt;
    logic              inter_r,  inter_nxt;
    logic              cmd_chop;
    logic [1:0]        bl_field;
    logic [BEAT_W-1:0] col_w;

    assign bl_field = mr_first_r[MRF_BL_HI:MRF_BL_LO];

    always_comb begin
        unique case (bl_field)
            BL_FIXED4: cmd_chop = 1'b1;
            BL_OTF:    cmd_chop = ~addr[CHOP_ADDR_BIT];
            default:   cmd_chop = 1'b0;
        endcase
    end

    always_comb begin
        state_nxt = state_r;
        beat_nxt  = beat_r;
        start_nxt = start_r;
        chop_nxt  = chop_r;
        inter_nxt = inter_r;
        unique case (state_r)
            BURST_IDLE: begin
                if (rd_cmd || wr_cmd) begin
                    state_nxt = rd_cmd ? BURST_READ : BURST_WRITE;
                    beat_nxt  = '0;
                    start_nxt = addr[BEAT_W-1:0];
                    chop_nxt  = cmd_chop;
                    inter_nxt = mr_first_r[MRF_BT];
                end
            end
            BURST_READ, BURST_WRITE: begin
                // A chopped burst still occupies all eight slots.
                beat_nxt = 3'(beat_r + 3'h1);
                if (beat_r == BEAT_LAST_FULL) begin
                    state_nxt = BURST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_r <= BURST_IDLE;
            beat_r  <= '0;
            start_r <= '0;
            chop_r  <= 1'b0;
            inter_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            beat_r  <= beat_nxt;
            start_r <= start_nxt;
            chop_r  <= chop_nxt;
            inter_r <= inter_nxt;
        end
    end

    beat_order u_order (
        .start_col  (start_r),
        .beat       (beat_r),
        .interleave (inter_r),
        .is_write   (state_r == BURST_WRITE),
        .chop       (chop_r),
        .col        (col_w)
    );

    ////////////////////////////////////////////////////////////////////////
    // Beat outputs and status.
    logic              active;
    logic              in_tail;
    logic              dll_on_nxt, dll_on_r;
    logic              rtt_wr_en;

    assign active  = (state_r != BURST_IDLE);
    assign in_tail = chop_r && (beat_r > BEAT_LAST_CHOP);
    assign rtt_wr_en = (mr_third_r[MRT_RTTWR_HI:MRT_RTTWR_LO] != 2'h0);

    always_comb begin
        // DLL stops in self-refresh and, in slow-exit mode, in precharge power-down.
        dll_on_nxt = ~mr_second_r[MRS_DLL_DIS] && ~self_refresh
                   && ~(precharge_pd && ~mr_first_r[MRF_PPD]);
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            beat_col         <= '0;
            beat_valid       <= 1'b0;
            beat_is_write    <= 1'b0;
            dq_drive_n       <= 1'b1;
            burst_interleave <= 1'b0;
            dll_reset_pulse  <= 1'b0;
            dll_on_r         <= 1'b0;
            dll_running      <= 1'b0;
            dll_bit          <= 1'b0;
            write_recovery   <= '0;
            slow_pd_exit     <= 1'b1;
            drive_strength   <= '0;
            rtt_nom_sel      <= '0;
            rtt_wr_sel       <= '0;
            rtt_wr_active    <= 1'b0;
            wr_needs_dll     <= 1'b0;
            wr_pull_in       <= '0;
        end else begin
            beat_col         <= col_w;
            // Tail slots of a chopped burst carry no data.
            beat_valid       <= active && !in_tail;
            beat_is_write    <= (state_r == BURST_WRITE);
            dq_drive_n       <= !((state_r == BURST_READ) && !in_tail);
            burst_interleave <= inter_r;
            dll_reset_pulse  <= dll_rst_r;
            dll_on_r         <= dll_on_nxt;
            dll_running      <= dll_on_r;
            dll_bit          <= mr_first_r[MRF_DLL_RST];
            write_recovery   <= mr_first_r[MRF_WR_HI:MRF_WR_LO];
            slow_pd_exit     <= ~mr_first_r[MRF_PPD];
            drive_strength   <= {mr_second_r[MRS_DRV_B], mr_second_r[MRS_DRV_A]};
            rtt_nom_sel      <= {mr_second_r[MRS_RTT_C], mr_second_r[MRS_RTT_B],
                                 mr_second_r[MRS_RTT_A]};
            rtt_wr_sel       <= mr_third_r[MRT_RTTWR_HI:MRT_RTTWR_LO];
            // Write termination during writes, independent of nominal setting.
            rtt_wr_active    <= (state_r == BURST_WRITE) && rtt_wr_en;
            wr_needs_dll     <= rtt_wr_en;
            wr_pull_in       <= (bl_field == BL_FIXED4) ? CHOP_WR_PULL_IN : 2'h0;
        end
    end
endmodule : mode_burst_ctrl
`default_nettype wire

// file: test/mode_burst_asserts.sv
// Port checks for the mode-register burst block.
`timescale 1ns/1ps
`default_nettype none
module mode_burst_asserts
    import mode_burst_pkg::*;
(
    input wire logic              clk_sys,
    input wire logic              reset,
    input wire logic              mrs_cmd,
    input wire logic [2:0]        bank,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic              self_refresh,
    input wire logic              beat_valid,
    input wire logic              beat_is_write,
    input wire logic              dq_drive_n,
    input wire logic              dll_reset_pulse,
    input wire logic              dll_running,
    input wire logic              dll_bit,
    input wire logic [2:0]        write_recovery,
    input wire logic              slow_pd_exit,
    input wire logic [1:0]        drive_strength,
    input wire logic [1:0]        rtt_wr_sel,
    input wire logic              rtt_wr_active,
    input wire logic              wr_needs_dll,
    input wire logic [1:0]        wr_pull_in
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    // Settings are checked three edges after the command, so the value is kept that long.
    logic [ADDR_W-1:0] a1_r, a2_r, a3_r;
    wire               mf = mrs_cmd && bank == BANK_MR_FIRST;
    wire               ms = mrs_cmd && bank == BANK_MR_SECOND;
    always_ff @(posedge clk_sys) {a3_r, a2_r, a1_r} <= {a2_r, a1_r, addr};
    // The reset pulse stands for one cycle only, two edges after the command is taken.
    AST_DLL_PULSE: assert property (mf && addr[MRF_DLL_RST] |-> ##2 dll_reset_pulse)
        else $error("dll reset pulse missing");
    AST_DLL_CLR: assert property (dll_bit |=> !dll_bit)
        else $error("dll reset bit did not clear");
    AST_WREC: assert property (mf |-> ##3 write_recovery == a3_r[MRF_WR_HI:MRF_WR_LO])
        else $error("write recovery wrong");
    AST_PD_EXIT: assert property (mf |-> ##3 slow_pd_exit == !a3_r[MRF_PPD])
        else $error("power-down exit mode wrong");
    AST_PULL: assert property (mf |-> ##3 wr_pull_in == (a3_r[1:0] == BL_FIXED4 ? CHOP_WR_PULL_IN : 2'h0))
        else $error("write pull-in wrong");
    AST_DRIVE: assert property (ms |-> ##3 drive_strength == {a3_r[MRS_DRV_B], a3_r[MRS_DRV_A]})
        else $error("driver strength wrong");
    AST_TAIL: assert property (!beat_valid |-> dq_drive_n)
        else $error("data driven outside a data slot");
    AST_RTT_WR: assert property (rtt_wr_active |-> beat_is_write && rtt_wr_sel != 2'h0)
        else $error("write termination outside a write");
    AST_NEED: assert property (wr_needs_dll == (rtt_wr_sel != 2'h0))
        else $error("dll need flag wrong");
    AST_SR: assert property (self_refresh [*3] |=> !dll_running)
        else $error("dll running in self refresh");
endmodule : mode_burst_asserts
bind mode_burst_ctrl mode_burst_asserts mode_burst_asserts_i (
    .clk_sys         (clk_sys),
    .reset           (reset),
    .mrs_cmd         (mrs_cmd),
    .bank            (bank),
    .addr            (addr),
    .self_refresh    (self_refresh),
    .beat_valid      (beat_valid),
    .beat_is_write   (beat_is_write),
    .dq_drive_n      (dq_drive_n),
    .dll_reset_pulse (dll_reset_pulse),
    .dll_running     (dll_running),
    .dll_bit         (dll_bit),
    .write_recovery  (write_recovery),
    .slow_pd_exit    (slow_pd_exit),
    .drive_strength  (drive_strength),
    .rtt_wr_sel      (rtt_wr_sel),
    .rtt_wr_active   (rtt_wr_active),
    .wr_needs_dll    (wr_needs_dll),
    .wr_pull_in      (wr_pull_in)
);
`default_nettype wire

// file: test/ctrl_model.sv
// Command side of the memory controller.
`timescale 1ns/1ps
`default_nettype none
module ctrl_model
    import mode_burst_pkg::*;
(
    input  wire logic              clk_sys,
    output logic                   mrs_cmd,
    output logic                   rd_cmd,
    output logic                   wr_cmd,
    output logic      [2:0]        bank,
    output logic      [ADDR_W-1:0] addr
);
    initial {wr_cmd, rd_cmd, mrs_cmd, bank, addr} = {3'h0, 3'h7, 14'h3fff};
    // Released bank and address lines carry the inverse so stale values cannot look valid.
    task automatic cmd(input logic [2:0] kind, input logic [2:0] b, input logic [ADDR_W-1:0] a);
        @(posedge clk_sys);
        {wr_cmd, rd_cmd, mrs_cmd} <= kind;
        bank <= b;
        addr <= a;
        @(posedge clk_sys);
        {wr_cmd, rd_cmd, mrs_cmd} <= 3'h0;
        bank <= ~b;
        addr <= ~a;
    endtask : cmd
endmodule : ctrl_model
`default_nettype wire

// file: test/mode_burst_ctrl_test.sv
// Directed bench for the mode-register burst block.
`timescale 1ns/1ps
`default_nettype none
module mode_burst_ctrl_test
    import mode_burst_pkg::*;
;
    logic              clk_sys, reset, mrs_cmd, rd_cmd, wr_cmd, self_refresh, precharge_pd;
    logic [2:0]        bank, beat_col, write_recovery, rtt_nom_sel;
    logic [ADDR_W-1:0] addr;
    logic [1:0]        drive_strength, rtt_wr_sel, wr_pull_in;
    logic              beat_valid, beat_is_write, dq_drive_n, burst_interleave, dll_reset_pulse;
    logic              dll_running, dll_bit, slow_pd_exit, rtt_wr_active, wr_needs_dll;
    int                bad_count = 0, total_checks = 0, cycles = 0;
    bit                rtt_on = 1'b0;
    mode_burst_ctrl mode_burst_ctrl_i (
        .clk_sys          (clk_sys),
        .reset            (reset),
        .mrs_cmd          (mrs_cmd),
        .rd_cmd           (rd_cmd),
        .wr_cmd           (wr_cmd),
        .bank             (bank),
        .addr             (addr),
        .self_refresh     (self_refresh),
        .precharge_pd     (precharge_pd),
        .beat_col         (beat_col),
        .beat_valid       (beat_valid),
        .beat_is_write    (beat_is_write),
        .dq_drive_n       (dq_drive_n),
        .burst_interleave (burst_interleave),
        .dll_reset_pulse  (dll_reset_pulse),
        .dll_running      (dll_running),
        .dll_bit          (dll_bit),
        .write_recovery   (write_recovery),
        .slow_pd_exit     (slow_pd_exit),
        .drive_strength   (drive_strength),
        .rtt_nom_sel      (rtt_nom_sel),
        .rtt_wr_sel       (rtt_wr_sel),
        .rtt_wr_active    (rtt_wr_active),
        .wr_needs_dll     (wr_needs_dll),
        .wr_pull_in       (wr_pull_in)
    );
    ctrl_model ctrl_model_i (
        .clk_sys (clk_sys),
        .mrs_cmd (mrs_cmd),
        .rd_cmd  (rd_cmd),
        .wr_cmd  (wr_cmd),
        .bank    (bank),
        .addr    (addr)
    );
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : close_out
    task automatic mrs(input logic [2:0] b, input logic [ADDR_W-1:0] v);
        ctrl_model_i.cmd(3'h1, b, v);
        repeat (2) @(posedge clk_sys);
        #1;
    endtask : mrs
    task automatic burst(input bit w, input logic [ADDR_W-1:0] a, input bit ch, input bit il);
        logic [2:0] s, e;
        s = a[2:0];
        ctrl_model_i.cmd(w ? 3'h4 : 3'h2, 3'h0, a);
        // Slot zero is on the outputs from the first edge after the command is taken.
        @(posedge clk_sys);
        for (int k = 0; k < 8; k++) begin
            #1;
            e = w ? (ch ? {s[2], 2'(k)} : 3'(k)) : (il ? s ^ 3'(k) : {s[2] ^ k[2], s[1:0] + 2'(k)});
            chk("valid", 16'(!ch || k < 4), 16'(beat_valid));
            chk("drive_n", 16'(w || (ch && k > 3)), 16'(dq_drive_n));
            if (!ch || k < 4) chk("col", 16'(e), 16'(beat_col));
            chk("is_write", 16'(w), 16'(beat_is_write));
            chk("inter", 16'(il), 16'(burst_interleave));
            chk("rtt_act", 16'(w && rtt_on), 16'(rtt_wr_active));
            @(posedge clk_sys);
        end
    endtask : burst
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            bad_count++;
            close_out();
        end
    end
    initial begin
        {reset, self_refresh, precharge_pd} = 3'h4;
        repeat (8) @(posedge clk_sys);
        reset <= 1'b0;
        #1;
        chk("rst", 16'h0018, 16'({dq_drive_n, slow_pd_exit, write_recovery}));
        for (int t = 0; t < 2; t++) begin
            mrs(BANK_MR_FIRST, 14'h1a00 | 14'(t << 3));
            chk("wr_rec", 16'h5, 16'(write_recovery));
            chk("slow_pd", 16'h0, 16'(slow_pd_exit));
            for (int s = 0; s < 8; s++) burst(1'b0, 14'(s), 1'b0, t[0]);
            burst(1'b1, 14'h0005, 1'b0, t[0]);
        end
        $display("test order done");
        mrs(BANK_MR_FIRST, 14'h0002);
        chk("pull_in", 16'(CHOP_WR_PULL_IN), 16'(wr_pull_in));
        burst(1'b0, 14'h0005, 1'b1, 1'b0);
        burst(1'b1, 14'h0006, 1'b1, 1'b0);
        mrs(BANK_MR_FIRST, 14'h0009);
        chk("pull_in", 16'h0, 16'(wr_pull_in));
        burst(1'b0, 14'h0003, 1'b1, 1'b1);
        burst(1'b0, 14'h1003, 1'b0, 1'b1);
        $display("test chop done");
        mrs(BANK_MR_SECOND, 14'h0023);
        chk("dll_off", 16'h0, 16'(dll_running));
        mrs(BANK_MR_SECOND, 14'h0066);
        chk("drive", 16'h3, 16'(drive_strength));
        chk("rtt_nom", 16'h3, 16'(rtt_nom_sel));
        // The reset pulse and the stored bit stand for one cycle, so look at each cycle.
        ctrl_model_i.cmd(3'h1, BANK_MR_FIRST, 14'h0100);
        @(posedge clk_sys);
        #1;
        chk("pulse", 16'h1, 16'(dll_reset_pulse));
        chk("dll_bit", 16'h1, 16'(dll_bit));
        @(posedge clk_sys);
        #1;
        chk("pulse", 16'h0, 16'(dll_reset_pulse));
        chk("dll_bit", 16'h0, 16'(dll_bit));
        repeat (16) @(posedge clk_sys);
        chk("dll_on", 16'h1, 16'(dll_running));
        {self_refresh, precharge_pd} <= 2'h2;
        repeat (4) @(posedge clk_sys);
        chk("sr", 16'h0, 16'(dll_running));
        {self_refresh, precharge_pd} <= 2'h1;
        repeat (4) @(posedge clk_sys);
        chk("pd_slow", 16'h0, 16'(dll_running));
        mrs(BANK_MR_FIRST, 14'h1000);
        repeat (3) @(posedge clk_sys);
        chk("pd_fast", 16'h1, 16'(dll_running));
        precharge_pd <= 1'b0;
        mrs(BANK_MR_THIRD, 14'h0200);
        chk("rtt_wr", 16'h0081, 16'({rtt_wr_sel, 6'h0, wr_needs_dll}));
        rtt_on = 1'b1;
        burst(1'b1, 14'h0002, 1'b0, 1'b0);
        $display("test dll done");
        close_out();
    end
endmodule : mode_burst_ctrl_test
`default_nettype wire
